// file: include/sbts_pkg.sv
// Package: constants of the servo brake and tuning sequencer
package sbts_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_PERIOD_PS = 5000;      // 200 MHz system clock
  localparam int unsigned TICK_PERIOD_NS = 1000000;  // One millisecond tick
  localparam int unsigned TICK_CYC = (TICK_PERIOD_NS * 1000) / CLK_PERIOD_PS;

  // ==========================================================
  // Register offsets (byte addresses)
  // ==========================================================
  localparam logic [7:0] ADR_CTRL = 8'h00;  // Mode, overtravel, rigidity level
  localparam logic [7:0] ADR_DBRK = 8'h04;  // Dynamic brake delay, inhibits
  localparam logic [7:0] ADR_HBRK = 8'h08;  // Holding brake timing, threshold
  localparam logic [7:0] ADR_FFWD = 8'h0C;  // Speed feedforward gain, smoothing
  localparam logic [7:0] ADR_MPOS = 8'h10;  // Manual position gain
  localparam logic [7:0] ADR_MSPD = 8'h14;  // Manual speed gain
  localparam logic [7:0] ADR_MINT = 8'h18;  // Manual speed integration constant
  localparam logic [7:0] ADR_MTRQ = 8'h1C;  // Manual torque filter constant
  localparam logic [7:0] ADR_STAT = 8'h20;  // Sequencer status, read only
  localparam logic [7:0] ADR_GPS  = 8'h24;  // Effective position and speed gain
  localparam logic [7:0] ADR_GIT  = 8'h28;  // Effective integration and filter

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int unsigned CTRL_OTM_LSB = 2;   // Overtravel stop mode bit
  localparam int unsigned CTRL_LVL_LSB = 8;   // Rigidity level, 5 bits
  localparam int unsigned DBRK_INH_LSB = 8;   // Four inhibit bits
  localparam int unsigned HBRK_MAX_LSB = 8;   // Maximum wait, 8 bits
  localparam int unsigned HBRK_THR_LSB = 16;  // Speed threshold, 12 bits
  localparam int unsigned FFWD_SMO_LSB = 16;  // Smoothing constant, 13 bits
  localparam int unsigned STAT_FLG_LSB = 8;   // Brake, power, dyn brake, lock

  // ==========================================================
  // Limits, fixed values and reset values
  // ==========================================================
  localparam logic [7:0]  DB_DELAY_MAX = 8'h96;       // 150 ms
  localparam logic [11:0] SPD_THR_MAX  = 12'hBB8;     // 3000 rpm
  localparam logic [9:0]  FF_GAIN_MAX  = 10'h3E8;     // 100.0 percent
  localparam logic [12:0] FF_SMO_MAX   = 13'h1900;    // 64.00 ms
  localparam logic [9:0]  FF_GAIN_FIX  = 10'h12C;     // 30.0 percent
  localparam logic [12:0] FF_SMO_FIX   = 13'h0032;    // 0.50 ms
  localparam logic [15:0] MAN_GAIN_RST = 16'h0064;    // Manual gains after reset
  localparam logic [1:0]  MODE_MANUAL  = 2'h0;        // Manual rigidity
  localparam logic [1:0]  MODE_POSN    = 2'h2;        // Positioning automatic
  localparam logic [1:0]  MODE_AUTO2   = 2'h3;        // Automatic rigidity 2

  // ==========================================================
  // Built-in rigidity table: base plus level times step
  // ==========================================================
  localparam logic [15:0] TBL_POS_BASE = 16'h0064;
  localparam logic [15:0] TBL_POS_STEP = 16'h0028;
  localparam logic [15:0] TBL_SPD_BASE = 16'h00C8;
  localparam logic [15:0] TBL_SPD_STEP = 16'h0050;
  localparam logic [15:0] TBL_INT_BASE = 16'h0BB8;
  localparam logic [15:0] TBL_INT_STEP = 16'h0064;
  localparam logic [15:0] TBL_TRQ_BASE = 16'h01F4;
  localparam logic [15:0] TBL_TRQ_STEP = 16'h000A;

  // ==========================================================
  // Servo sequence states, one-hot
  // ==========================================================
  typedef enum logic [4:0] {
    ST_OFF    = 5'b00001,  // Unpowered, holding brake closed
    ST_ENGAGE = 5'b00010,  // Powered, commands held off
    ST_RUN    = 5'b00100,  // Powered, commands accepted
    ST_STILL  = 5'b01000,  // Brake closed, still powered
    ST_SPIN   = 5'b10000   // Coasting, waiting for brake point
  } sbts_state_e;

endpackage : sbts_pkg

// file: rtl/sbts_sequencer.sv
// Servo brake timing, overtravel stop and rigidity gain selection
// How it works
// - Auto modes load gains from rigidity table; torque filter only in modes 1-2
// - Owned manual gain writes have no effect
// - Positioning mode fixes feedforward at 30.0%/0.50
// - Overtravel: free or locked, opposite commands only
// - Dynamic brake waits 0-150 ms delay
// - Four single-bit dynamic brake inhibits
// - After enable, commands wait hold delay
// - Stationary disable: brake first, then unpower
// - Rotating disable: brake below speed threshold
// - Rotating disable: brake after maximum wait
//
// Decided for this implementation: the strobed register port and the placing of the registers.
module sbts_sequencer #(
  parameter int unsigned TICK_CYC = sbts_pkg::TICK_CYC  // Clock cycles per ms tick
) (
  input  wire logic        i_clk,            // 200 MHz system clock
  input  wire logic        i_rst_n,          // Asynchronous reset, active low
  input  wire logic [7:0]  i_addr,           // Register byte address
  input  wire logic [31:0] i_wdata,          // Register write data
  input  wire logic        i_wr,             // Write strobe
  input  wire logic        i_rd,             // Read strobe
  output logic      [31:0] o_rdata,          // Read data, cycle after strobe
  input  wire logic        i_servo_on,       // Servo enable command level
  input  wire logic        i_mains_ok,       // Main power present
  input  wire logic        i_fault,          // Fault alarm active
  input  wire logic        i_ot_fwd,         // Forward overtravel limit hit
  input  wire logic        i_ot_rev,         // Reverse overtravel limit hit
  input  wire logic [11:0] i_motor_speed,    // Motor speed magnitude, rpm
  input  wire logic        i_pos_cmd_valid,  // Position command offered
  input  wire logic        i_pos_cmd_dir,    // Command direction, 1 forward
  output logic             o_pos_cmd_accept, // Position command taken
  output logic             o_motor_power,    // Motor energized
  output logic             o_hold_brake,     // Holding brake closed
  output logic             o_dyn_brake,      // Dynamic brake engaged
  output logic             o_ot_lock,        // Locked at overtravel
  output logic      [15:0] o_pos_gain,       // Effective position gain
  output logic      [15:0] o_spd_gain,       // Effective speed gain
  output logic      [15:0] o_spd_integ,      // Effective speed integration
  output logic      [15:0] o_trq_filt,       // Effective torque filter
  output logic      [9:0]  o_ff_gain,        // Effective feedforward gain
  output logic      [12:0] o_ff_smooth       // Effective feedforward smoothing
);

  // ==========================================================
  // Elaboration check
  // ==========================================================
  localparam int TW = $clog2(TICK_CYC);  // Tick counter width
  if (TICK_CYC < 2)
  begin : g_bad_tick
    $error("TICK_CYC must be at least 2");
  end

  // Table entry for one gain at a given rigidity level
  function automatic logic [15:0] tbl(input logic [15:0] base, input logic [15:0] step,
                                      input logic [4:0] lvl);
    tbl = 16'(base + 16'(step * {11'h000, lvl}));
  endfunction : tbl

  // ==========================================================
  // Millisecond tick
  // ==========================================================
  logic [TW-1:0] tick_cnt_q;  // Cycle counter within a tick
  logic          tick_q;      // One-cycle tick pulse
  wire           tick_wrap = (tick_cnt_q == TW'(TICK_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end
    else
    begin
      tick_cnt_q <= tick_wrap ? '0 : TW'(tick_cnt_q + 1'b1);
      tick_q     <= tick_wrap;
    end
  end

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic [1:0]  mode_q;       // auto_rigidity_mode_sel
  logic        ot_mode_q;    // overtravel_stop_mode
  logic [4:0]  level_q;      // rigidity_level
  logic [7:0]  db_delay_q;   // dyn_brake_delay
  logic [3:0]  db_inh_q;     // Inhibits: mains, servo off, fault, overtravel
  logic [7:0]  hb_delay_q;   // hold_brake_delay
  logic [7:0]  hb_max_q;     // hold_brake_max_wait
  logic [11:0] hb_thr_q;     // hold_brake_speed_threshold
  logic [9:0]  ff_gain_q;    // speed_ff_gain, user value
  logic [12:0] ff_smo_q;     // speed_ff_smoothing, user value
  logic [15:0] man_q [4];    // Manual gains: position, speed, integ, torque

  // Write decode
  wire wr_ctrl = i_wr && (i_addr == sbts_pkg::ADR_CTRL);
  wire wr_dbrk = i_wr && (i_addr == sbts_pkg::ADR_DBRK);
  wire wr_hbrk = i_wr && (i_addr == sbts_pkg::ADR_HBRK);
  // Feedforward writes refused in positioning mode
  wire wr_ffwd = i_wr && (i_addr == sbts_pkg::ADR_FFWD) && (mode_q != sbts_pkg::MODE_POSN);
  wire [7:0]  w_dly = i_wdata[7:0];
  wire [11:0] w_thr = i_wdata[sbts_pkg::HBRK_THR_LSB +: 12];
  wire [9:0]  w_ffg = i_wdata[9:0];
  wire [12:0] w_ffs = i_wdata[sbts_pkg::FFWD_SMO_LSB +: 13];

  // Control fields; out-of-range values clamp to the documented maximum
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      mode_q     <= sbts_pkg::MODE_MANUAL;
      ot_mode_q  <= 1'b0;
      level_q    <= '0;
      db_delay_q <= '0;
      db_inh_q   <= '0;
      hb_delay_q <= '0;
      hb_max_q   <= '0;
      hb_thr_q   <= '0;
      ff_gain_q  <= '0;
      ff_smo_q   <= '0;
    end
    else
    begin
      if (wr_ctrl)
      begin
        mode_q    <= i_wdata[1:0];
        ot_mode_q <= i_wdata[sbts_pkg::CTRL_OTM_LSB];
        level_q   <= i_wdata[sbts_pkg::CTRL_LVL_LSB +: 5];
      end
      // Delay range limited to 150 ms
      if (wr_dbrk)
      begin
        db_delay_q <= (w_dly > sbts_pkg::DB_DELAY_MAX) ? sbts_pkg::DB_DELAY_MAX : w_dly;
        db_inh_q   <= i_wdata[sbts_pkg::DBRK_INH_LSB +: 4];
      end
      if (wr_hbrk)
      begin
        hb_delay_q <= w_dly;
        hb_max_q   <= i_wdata[sbts_pkg::HBRK_MAX_LSB +: 8];
        hb_thr_q   <= (w_thr > sbts_pkg::SPD_THR_MAX) ? sbts_pkg::SPD_THR_MAX : w_thr;
      end
      if (wr_ffwd)
      begin
        ff_gain_q <= (w_ffg > sbts_pkg::FF_GAIN_MAX) ? sbts_pkg::FF_GAIN_MAX : w_ffg;
        ff_smo_q  <= (w_ffs > sbts_pkg::FF_SMO_MAX) ? sbts_pkg::FF_SMO_MAX : w_ffs;
      end
    end
  end

  // Manual gains are always stored; whether they act depends on the mode
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      for (int i = 0; i < 4; i++) man_q[i] <= sbts_pkg::MAN_GAIN_RST;
    else if (i_wr && (i_addr[7:4] == 4'h1))
      man_q[i_addr[3:2]] <= i_wdata[15:0];
  end

  // ==========================================================
  // Gain selection
  // ==========================================================
  wire auto_on  = (mode_q != sbts_pkg::MODE_MANUAL);
  wire trq_auto = auto_on && (mode_q != sbts_pkg::MODE_AUTO2);  // Mode 3 leaves filter
  wire posn     = (mode_q == sbts_pkg::MODE_POSN);

  // Auto modes take the table entry, except torque filter in mode 3; other manual values ignored
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pos_gain  <= sbts_pkg::MAN_GAIN_RST;
      o_spd_gain  <= sbts_pkg::MAN_GAIN_RST;
      o_spd_integ <= sbts_pkg::MAN_GAIN_RST;
      o_trq_filt  <= sbts_pkg::MAN_GAIN_RST;
      o_ff_gain   <= '0;
      o_ff_smooth <= '0;
    end
    else
    begin
      o_pos_gain  <= auto_on ? tbl(sbts_pkg::TBL_POS_BASE, sbts_pkg::TBL_POS_STEP, level_q)
                             : man_q[0];
      o_spd_gain  <= auto_on ? tbl(sbts_pkg::TBL_SPD_BASE, sbts_pkg::TBL_SPD_STEP, level_q)
                             : man_q[1];
      o_spd_integ <= auto_on ? tbl(sbts_pkg::TBL_INT_BASE, sbts_pkg::TBL_INT_STEP, level_q)
                             : man_q[2];
      o_trq_filt  <= trq_auto ? tbl(sbts_pkg::TBL_TRQ_BASE, sbts_pkg::TBL_TRQ_STEP, level_q)
                              : man_q[3];
      o_ff_gain   <= posn ? sbts_pkg::FF_GAIN_FIX : ff_gain_q;
      o_ff_smooth <= posn ? sbts_pkg::FF_SMO_FIX : ff_smo_q;
    end
  end

  // ==========================================================
  // Servo on/off sequence
  // ==========================================================
  sbts_pkg::sbts_state_e st_q, st_d;  // Sequence state
  logic [7:0]            ms_cnt_q;    // Milliseconds in current state
  wire abort    = i_fault || !i_mains_ok;  // Forces immediate power removal
  wire ms_gt_hb = (ms_cnt_q >= hb_delay_q);
  wire ot_hit   = i_ot_fwd || i_ot_rev;

  // Next state
  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      sbts_pkg::ST_OFF:
        if (i_servo_on && !abort) st_d = sbts_pkg::ST_ENGAGE;
      // Hold commands until enable delay elapses
      sbts_pkg::ST_ENGAGE:
        if (abort || !i_servo_on) st_d = sbts_pkg::ST_OFF;
        else if (ms_gt_hb)        st_d = sbts_pkg::ST_RUN;
      // Stationary or rotating disable path
      sbts_pkg::ST_RUN:
        if (abort)                     st_d = sbts_pkg::ST_OFF;
        else if (!i_servo_on)
          st_d = (i_motor_speed == 12'h000) ? sbts_pkg::ST_STILL : sbts_pkg::ST_SPIN;
      // Brake closed, power kept for the delay
      sbts_pkg::ST_STILL:
        if (abort || ms_gt_hb) st_d = sbts_pkg::ST_OFF;
      // Brake below threshold; or after maximum wait
      sbts_pkg::ST_SPIN:
        if (abort || (i_motor_speed < hb_thr_q) || (ms_cnt_q >= hb_max_q))
          st_d = sbts_pkg::ST_OFF;
      default: st_d = sbts_pkg::ST_OFF;  // Illegal code recovers to off
    endcase
  end

  // Brake closed in off and stationary stop; power in all but off and coast
  wire hb_d  = (st_d == sbts_pkg::ST_OFF) || (st_d == sbts_pkg::ST_STILL);
  wire pw_on = (st_d == sbts_pkg::ST_ENGAGE) || (st_d == sbts_pkg::ST_RUN) ||
               (st_d == sbts_pkg::ST_STILL);
  // Free stop unpowers; locked stop holds power
  wire pwr_d  = pw_on && !(ot_hit && !ot_mode_q);
  wire lock_d = pw_on && ot_hit && ot_mode_q;

  // State, millisecond counter and brake/power outputs
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q          <= sbts_pkg::ST_OFF;
      ms_cnt_q      <= '0;
      o_hold_brake  <= 1'b1;
      o_motor_power <= 1'b0;
      o_ot_lock     <= 1'b0;
    end
    else
    begin
      st_q          <= st_d;
      ms_cnt_q      <= (st_d != st_q) ? '0 :
                       (tick_q && (ms_cnt_q != 8'hFF)) ? 8'(ms_cnt_q + 1'b1) : ms_cnt_q;
      o_hold_brake  <= hb_d;
      o_motor_power <= pwr_d;
      o_ot_lock     <= lock_d;
    end
  end

  // Only commands away from the hit limit; only once running
  assign o_pos_cmd_accept = i_pos_cmd_valid && (st_q == sbts_pkg::ST_RUN) &&
                            !(i_ot_fwd && i_pos_cmd_dir) && !(i_ot_rev && !i_pos_cmd_dir);

  // ==========================================================
  // Dynamic brake
  // ==========================================================
  logic [7:0] db_cnt_q;  // Milliseconds since braking conditions met
  // Each cause gated by its own inhibit
  wire db_cause = (!i_mains_ok && !db_inh_q[0]) || (!i_servo_on && !db_inh_q[1]) ||
                  (i_fault && !db_inh_q[2]) || (ot_hit && !db_inh_q[3]);
  // Only a motor unpowered in the previous cycle is shorted; can overlap power-on by one cycle
  wire db_cond  = db_cause && !o_motor_power;

  // Engage once the delay has passed
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      db_cnt_q    <= '0;
      o_dyn_brake <= 1'b0;
    end
    else
    begin
      db_cnt_q    <= !db_cond ? '0 :
                     (tick_q && (db_cnt_q < db_delay_q)) ? 8'(db_cnt_q + 1'b1) : db_cnt_q;
      o_dyn_brake <= db_cond && (db_cnt_q >= db_delay_q);
    end
  end

  // ==========================================================
  // Read port
  // ==========================================================
  wire [31:0] rd_mux =
    (i_addr == sbts_pkg::ADR_CTRL) ? {19'h0_0000, level_q, 5'h00, ot_mode_q, mode_q} :
    (i_addr == sbts_pkg::ADR_DBRK) ? {20'h0_0000, db_inh_q, db_delay_q} :
    (i_addr == sbts_pkg::ADR_HBRK) ? {4'h0, hb_thr_q, hb_max_q, hb_delay_q} :
    (i_addr == sbts_pkg::ADR_FFWD) ? {3'h0, o_ff_smooth, 6'h00, o_ff_gain} :
    (i_addr[7:4] == 4'h1)          ? {16'h0000, man_q[i_addr[3:2]]} :
    (i_addr == sbts_pkg::ADR_STAT) ? {20'h0_0000, o_ot_lock, o_dyn_brake, o_motor_power,
                                      o_hold_brake, 3'h0, st_q} :
    (i_addr == sbts_pkg::ADR_GPS)  ? {o_spd_gain, o_pos_gain} :
    (i_addr == sbts_pkg::ADR_GIT)  ? {o_trq_filt, o_spd_integ} : 32'h0000_0000;

  // Data valid only in the cycle after a read strobe
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n) o_rdata <= '0;
    else          o_rdata <= i_rd ? rd_mux : 32'h0000_0000;
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_tick_gap;
    @(posedge i_clk) disable iff (!i_rst_n) tick_q |=> !tick_q;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too dense");

  property p_table;
    @(posedge i_clk) disable iff (!i_rst_n) auto_on |=>
      o_pos_gain == tbl(sbts_pkg::TBL_POS_BASE, sbts_pkg::TBL_POS_STEP, $past(level_q));
  endproperty
  a_table: assert property (p_table) else $error("position gain not from table");

  property p_manual_ignored;
    @(posedge i_clk) disable iff (!i_rst_n) (mode_q == 2'h1) ##1 (mode_q == 2'h1) |->
      o_spd_integ == tbl(sbts_pkg::TBL_INT_BASE, sbts_pkg::TBL_INT_STEP, $past(level_q));
  endproperty
  a_manual_ignored: assert property (p_manual_ignored) else $error("manual integ acted");

  property p_ff_fixed;
    @(posedge i_clk) disable iff (!i_rst_n) posn ##1 posn |->
      (o_ff_gain == sbts_pkg::FF_GAIN_FIX) && (o_ff_smooth == sbts_pkg::FF_SMO_FIX);
  endproperty
  a_ff_fixed: assert property (p_ff_fixed) else $error("feedforward not fixed");

  property p_ot_dir;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_ot_fwd && i_pos_cmd_dir) || (i_ot_rev && !i_pos_cmd_dir) |-> !o_pos_cmd_accept;
  endproperty
  a_ot_dir: assert property (p_ot_dir) else $error("command toward limit taken");

  property p_db_delay;
    @(posedge i_clk) disable iff (!i_rst_n) $rose(o_dyn_brake) |-> $past(db_cnt_q) >= db_delay_q;
  endproperty
  a_db_delay: assert property (p_db_delay) else $error("dynamic brake too early");

  property p_db_inhibit;
    @(posedge i_clk) disable iff (!i_rst_n) (db_inh_q == 4'hF) |=> !o_dyn_brake;
  endproperty
  a_db_inhibit: assert property (p_db_inhibit) else $error("inhibited brake engaged");

  property p_engage_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_q == sbts_pkg::ST_ENGAGE) |-> !o_pos_cmd_accept && (ms_cnt_q <= hb_delay_q);
  endproperty
  a_engage_hold: assert property (p_engage_hold) else $error("command before delay");

  property p_still;
    @(posedge i_clk) disable iff (!i_rst_n)
      $past(st_q == sbts_pkg::ST_STILL) && (st_q == sbts_pkg::ST_STILL) && !ot_hit |->
      o_hold_brake && o_motor_power;
  endproperty
  a_still: assert property (p_still) else $error("stationary stop order wrong");

  property p_spin_thr;
    @(posedge i_clk) disable iff (!i_rst_n)
      (st_q == sbts_pkg::ST_SPIN) && (i_motor_speed < hb_thr_q) |=> o_hold_brake;
  endproperty
  a_spin_thr: assert property (p_spin_thr) else $error("brake late below threshold");

  property p_spin_max;
    @(posedge i_clk) disable iff (!i_rst_n) (st_q == sbts_pkg::ST_SPIN) |-> ms_cnt_q <= hb_max_q;
  endproperty
  a_spin_max: assert property (p_spin_max) else $error("maximum wait exceeded");

  c_run:  cover property (@(posedge i_clk) disable iff (!i_rst_n) st_q == sbts_pkg::ST_RUN);
  c_db:   cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_dyn_brake));
  c_spin: cover property (@(posedge i_clk) disable iff (!i_rst_n)
                          (st_q == sbts_pkg::ST_SPIN) && (ms_cnt_q == hb_max_q));
  c_still: cover property (@(posedge i_clk) disable iff (!i_rst_n) st_q == sbts_pkg::ST_STILL);

endmodule : sbts_sequencer

// file: sim/sbts_motor_model.sv
// Motor model: driven speed, coasting decay and holding brake stop
module sbts_motor_model #(
  parameter int unsigned DECEL = 50  // Rpm lost per cycle while coasting
) (
  input  wire logic        i_clk,    // System clock
  input  wire logic        i_power,  // Windings energized
  input  wire logic        i_brake,  // Holding brake closed
  input  wire logic [11:0] i_target, // Speed reached when powered
  output logic      [11:0] o_speed   // Speed magnitude, rpm
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] speed_q = 12'h000;  // Starts at rest
  assign o_speed = speed_q;
  // ==========================================================
  // Brake wins over drive; coasting never wraps below zero
  // ==========================================================
  always @(posedge i_clk)
  begin
    if (i_brake)
      speed_q <= 12'h000;
    else if (i_power)
      speed_q <= i_target;
    else
      speed_q <= (speed_q > DECEL[11:0]) ? speed_q - DECEL[11:0] : 12'h000;
  end
endmodule : sbts_motor_model

// file: sim/sbts_sequencer_tb.sv
// Self-checking bench of the servo brake and tuning sequencer
module sbts_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 10;  // Short ms tick keeps the run brief
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_servo_on = 1'b0;
  logic i_mains_ok = 1'b1, i_fault = 1'b0, i_ot_fwd = 1'b0, i_ot_rev = 1'b0;
  logic i_pos_cmd_valid = 1'b0, i_pos_cmd_dir = 1'b0, o_rdy, o_pwr, o_hbk, o_dbk, o_lck;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000, o_rdata, mp, mt, l;
  logic [11:0] spd, tgt = 12'h000;
  logic [15:0] o_pg, o_sg, o_si, o_tf;
  logic [9:0] o_ffg;
  logic [12:0] o_ffs;
  int err_count = 0, samples_checked = 0;
  wire [3:0] ev = {o_hbk, ~o_pwr, o_dbk, o_rdy};  // Events waited on
  sbts_sequencer #(.TICK_CYC(T)) uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_servo_on(i_servo_on),
    .i_mains_ok(i_mains_ok), .i_fault(i_fault), .i_ot_fwd(i_ot_fwd), .i_ot_rev(i_ot_rev),
    .i_motor_speed(spd), .i_pos_cmd_valid(i_pos_cmd_valid), .i_pos_cmd_dir(i_pos_cmd_dir),
    .o_pos_cmd_accept(o_rdy), .o_motor_power(o_pwr), .o_hold_brake(o_hbk),
    .o_dyn_brake(o_dbk), .o_ot_lock(o_lck), .o_pos_gain(o_pg), .o_spd_gain(o_sg),
    .o_spd_integ(o_si), .o_trq_filt(o_tf), .o_ff_gain(o_ffg), .o_ff_smooth(o_ffs));
  sbts_motor_model u_motor (.i_clk(i_clk), .i_power(o_pwr), .i_brake(o_hbk),
    .i_target(tgt), .o_speed(spd));
  // ==========================================================
  // Clock, watchdog and shared tasks
  // ==========================================================
  initial
  begin
    forever #2.5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    stop_test();
  end
  task stop_test;
    $display("Checks: %0d, errors: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
      begin
        err_count++;
        $display("Error at %0t ns: got %h, expected %h", $time, g, e);
      end
  endtask : chk
  // One-cycle strobes, data checked in the cycle after a read
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd
  // Bounded wait for event s; tick phase allows one ms of slack
  task tmo(input int s, input int k);
    int n;
    n = 0;
    while (ev[s] !== 1'b1 && n < 3000)
      begin
        @(posedge i_clk);
        #1 n++;
      end
    chk(32'(n >= (k - 1) * T - 3 && n <= (k + 1) * T + 4), 32'h0000_0001);
  endtask : tmo
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    void'($urandom(66));
    repeat (10) @(posedge i_clk);
    #1 chk({o_hbk, o_pwr, o_pg}, 32'h0002_0064);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(8'h30, 32'h0000_0000);
    mt = $urandom & 32'h0000_FFFF;
    wr(sbts_pkg::ADR_MTRQ, mt);
    for (int m = 1; m < 4; m++)
      begin
        l = $urandom_range(31);
        mp = $urandom & 32'h0000_FFFF;
        wr(sbts_pkg::ADR_CTRL, (l << 8) | 32'(m));
        wr(sbts_pkg::ADR_MPOS, mp);
        repeat (3) @(posedge i_clk);
        #1 chk(o_pg, 100 + 40 * l);
        chk({o_sg, o_si}, {16'(200 + 80 * l), 16'(3000 + 100 * l)});
        chk(o_tf, (m == 3) ? mt : 500 + 10 * l);
      end
    wr(sbts_pkg::ADR_CTRL, 32'h0000_1F02);
    wr(sbts_pkg::ADR_FFWD, 32'h0010_0064);
    rd(sbts_pkg::ADR_FFWD, 32'h0032_012C);
    chk({o_ffs, o_ffg}, {13'h0032, 10'h12C});
    wr(sbts_pkg::ADR_CTRL, 32'h0000_0000);
    rd(sbts_pkg::ADR_FFWD, 32'h0000_0000);
    wr(sbts_pkg::ADR_FFWD, 32'h1FFF_03FF);
    rd(sbts_pkg::ADR_FFWD, 32'h1900_03E8);
    chk(o_pg, mp);
    chk(o_dbk, 1);
    wr(sbts_pkg::ADR_HBRK, 32'h01F4_1404);
    wr(sbts_pkg::ADR_DBRK, 32'h0000_0F00);
    for (int b = 0; b < 4; b++)
      begin
        wr(sbts_pkg::ADR_DBRK, 32'((~(1 << b) & 4'hF) << 8));
        i_servo_on <= (b != 1);
        i_mains_ok <= (b != 0);
        i_fault <= (b == 2);
        i_ot_fwd <= (b == 3);
        tmo(1, 0);
        if (b == 3) chk(o_pwr, 0);
        wr(sbts_pkg::ADR_DBRK, 32'h0000_0F00);
        repeat (4) @(posedge i_clk);
        #1 chk(o_dbk, 0);
        @(posedge i_clk);
        {i_servo_on, i_mains_ok, i_fault, i_ot_fwd} <= 4'h4;
      end
    wr(sbts_pkg::ADR_DBRK, 32'h0000_0003);
    i_pos_cmd_valid <= 1'b1;
    i_pos_cmd_dir <= 1'($urandom);
    i_servo_on <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk({o_pwr, o_hbk}, 32'h0000_0002);
    tmo(0, 4);
    wr(sbts_pkg::ADR_CTRL, 32'h0000_0004);
    i_ot_fwd <= 1'b1;
    i_pos_cmd_dir <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1 chk({o_lck, o_pwr, o_rdy}, 32'h0000_0006);
    @(posedge i_clk);
    i_pos_cmd_dir <= 1'b0;
    #1 chk(o_rdy, 1);
    @(posedge i_clk);
    {i_ot_fwd, i_ot_rev} <= 2'b01;
    #1 chk(o_rdy, 0);
    @(posedge i_clk);
    i_pos_cmd_dir <= 1'b1;
    #1 chk({o_lck, o_rdy}, 32'h0000_0003);
    @(posedge i_clk);
    i_ot_rev <= 1'b0;
    i_servo_on <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 chk({o_hbk, o_pwr}, 32'h0000_0003);
    tmo(2, 4);
    tmo(1, 3);
    for (int r = 0; r < 2; r++)
      begin
        @(posedge i_clk);
        i_servo_on <= 1'b1;
        tgt <= (r == 0) ? 12'd2000 : 12'($urandom_range(2000, 1000));
        tmo(0, 4);
        @(posedge i_clk);
        i_servo_on <= 1'b0;
        tmo(3, (r == 0) ? 3 : 5);
        if (r == 0) chk(32'(spd < 500 && spd >= 300), 32'h0000_0001);
        if (r == 0) wr(sbts_pkg::ADR_HBRK, 32'h0000_0504);
      end
    stop_test();
  end
endmodule : sbts_sequencer_tb
